//--- program_flow_sequencer.sv
// Fetch address sequencing, delayed jumps and interrupt entry control.
`timescale 1ns/1ns
`default_nettype none
module program_flow_sequencer
    import program_flow_pkg::*;
(
    input wire logic clk_in,            // Processor clock, 125 MHz.
    input wire logic reset_in,          // Synchronous reset, active high.
    input wire exec_op_t exec_op_in,    // Instruction in execute stage.
    input wire op_kind_t decode_kind_in,// Class of instruction in decode.
    input wire addr_t loop_count_in,    // Count operand of loop start.
    input wire reg_write_t reg_wr_in,   // Explicit register writes.
    input wire logic irq_req_in,        // Arbiter interrupt request.
    input wire addr_t irq_vector_in,    // Arbiter vector address.
    output addr_t fetch_addr_out,       // Instruction fetch address.
    output logic exec_cancel_out,       // Execute stage holds a no-op.
    output logic irq_accept_out,        // Request taken this cycle.
    output int_state_t int_state_out,   // Interrupt entry state.
    output logic loop_restart_out,      // New loop round this cycle.
    output addr_t pc_out,               // Program counter.
    output addr_t indirect_link_out,    // Indirect link register.
    output addr_t return_link_out,      // Return link register.
    output addr_t mode_flag_out,        // Mode and flag register.
    output addr_t saved_mode_out,       // Saved mode register.
    output addr_t instr_page_out,       // Instruction page register.
    output addr_t saved_page_out,       // Saved page register.
    output addr_t loop_start_out,       // Loop start register.
    output addr_t loop_end_out,         // Loop end register.
    output addr_t loop_count_out        // Loop count register.
);
    // Sequencer state kept in one record.
    typedef struct packed {
        int_state_t st;
        logic kill;
        logic hold;
        logic hold_ext;
        logic c1_cof;
        logic c1_at_end;
        addr_t pc;
    } seq_state_t;

    seq_state_t s;
    seq_state_t next_s;

    // Decoded execute-stage actions.
    logic exec_valid;
    logic take_target;
    logic take_indirect;
    logic take_return;
    logic loop_exec;
    logic clears_loop_flag;
    logic exec_cof;
    addr_t normal_fetch;
    addr_t fetch_addr;
    addr_t vector_addr;
    logic cancel_c1;

    // Register plumbing.
    addr_t indirect_link;
    addr_t return_link;
    addr_t mode_flag;
    addr_t instr_page;
    addr_t loop_start;
    logic loop_at_end;
    logic loop_restart;
    logic lr1_auto_en;
    addr_t lr1_auto_data;
    logic mode_auto_en;
    addr_t mode_auto_data;
    logic loop_inhibit;

    // A cancelled slot executes as a no-op, so its class is ignored.
    assign exec_valid = !s.kill;
    assign take_target = exec_valid &&
        ((exec_op_in.kind == OP_JUMP) || (exec_op_in.kind == OP_VECTOR) ||
         (((exec_op_in.kind == OP_COND_JUMP) ||
           (exec_op_in.kind == OP_COND_CALL)) && exec_op_in.cond_true));
    assign take_indirect = exec_valid && (exec_op_in.kind == OP_REG_JUMP) &&
                           exec_op_in.cond_true;
    assign take_return = exec_valid &&
                         (exec_op_in.kind == OP_IRET);
    assign loop_exec = exec_valid && (exec_op_in.kind == OP_LOOP);
    assign exec_cof = exec_valid && is_cof(exec_op_in.kind);
    assign clears_loop_flag = exec_valid &&
        ((exec_op_in.kind == OP_JUMP) || (exec_op_in.kind == OP_COND_JUMP) ||
         (exec_op_in.kind == OP_REG_JUMP) || (exec_op_in.kind == OP_IRET) ||
         (exec_op_in.kind == OP_COND_CALL) || (exec_op_in.kind == OP_LOOP));

    // The vector is folded into the table range, so a stray arbiter value
    // still lands inside the jump table instead of random code.
    assign vector_addr = VECTOR_BASE |
        (irq_vector_in & VECTOR_MASK);

    // Normal fetch address: the jump destination, or the counter.
    always_comb
    begin
        if (take_target)
            normal_fetch = exec_op_in.target;
        else if (take_indirect)
            normal_fetch = indirect_link;
        else if (take_return)
            normal_fetch = return_link;
        else
            normal_fetch = s.pc;
    end

    // In the second entry cycle the handler vector replaces it.
    assign fetch_addr = (s.st == INT_C2) ? vector_addr
                                         : normal_fetch;

    // The cycle-one fetch survives only behind a flow change or loop end.
    assign cancel_c1 = !(s.c1_cof || s.c1_at_end);

    // Return link auto loads: fetch address in cycle one, destination in
    // cycle two when the cycle-one instruction is kept.
    always_comb
    begin
        lr1_auto_en = 1'b0;
        lr1_auto_data = fetch_addr;
        case (s.st)
            INT_C1:
            begin
                lr1_auto_en = 1'b1;
                lr1_auto_data = fetch_addr;
            end
            INT_C2:
            begin
                lr1_auto_en = !cancel_c1;
                lr1_auto_data = normal_fetch;
            end
            default:
            begin
                lr1_auto_en = 1'b0;
                lr1_auto_data = fetch_addr;
            end
        endcase
    end

    // The loop-inhibit flag is set on entry and dropped by flow changes;
    // entry wins when both land in the same cycle, to protect the handler.
    always_comb
    begin
        mode_auto_en = 1'b0;
        mode_auto_data = mode_flag;
        if (clears_loop_flag)
        begin
            mode_auto_en = 1'b1;
            mode_auto_data[LOOP_FLAG_BIT] = 1'b0;
        end
        if (s.st == INT_C2)
        begin
            mode_auto_en = 1'b1;
            mode_auto_data[LOOP_FLAG_BIT] = 1'b1;
        end
    end

    assign loop_inhibit = mode_flag[LOOP_FLAG_BIT];

    // Request is taken only from idle and after the handler head has run.
    assign irq_accept_out = (s.st == INT_IDLE) && irq_req_in &&
                            !s.hold;

    // Next state of the sequencer.
    always_comb
    begin
        next_s = s;
        next_s.kill = 1'b0;
        // Counter follows the fetch, or jumps back on a new loop round.
        if (loop_restart)
            next_s.pc = loop_exec ? fetch_addr : loop_start;
        else
            next_s.pc = fetch_addr + ADDR_STEP;
        // A vector jump voids the instruction sitting in its delay slot.
        if (exec_valid && (exec_op_in.kind == OP_VECTOR))
            next_s.kill = 1'b1;
        case (s.st)
            INT_IDLE:
            begin
                if (irq_accept_out)
                    next_s.st = INT_C1;
                if (s.hold)
                begin
                    // Third handler instruction executes now; a flow change
                    // there keeps the gate shut for its delay slot too.
                    if (!s.hold_ext && exec_cof)
                        next_s.hold_ext = 1'b1;
                    else
                        next_s.hold = 1'b0;
                end
            end
            INT_C1:
            begin
                next_s.st = INT_C2;
                next_s.c1_cof = is_cof(decode_kind_in);
                next_s.c1_at_end = loop_at_end;
            end
            INT_C2:
            begin
                next_s.st = INT_C3;
                if (cancel_c1)
                    next_s.kill = 1'b1;
            end
            INT_C3:
                next_s.st = INT_C4;
            INT_C4:
                next_s.st = INT_C5;
            INT_C5:
            begin
                next_s.st = INT_IDLE;
                next_s.hold = 1'b1;
                next_s.hold_ext = 1'b0;
            end
            default:
                next_s.st = INT_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            s <= '{st: INT_IDLE, kill: 1'b0, hold: 1'b0, hold_ext: 1'b0,
                   c1_cof: 1'b0, c1_at_end: 1'b0, pc: RESET_VECTOR};
        else
            s <= next_s;
    end

    // Loop registers and loop end detection.
    loop_unit u_loop (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .fetch_addr_in(fetch_addr),
        .inhibit_in(loop_inhibit),
        .loop_exec_in(loop_exec),
        .loop_end_in(exec_op_in.target),
        .loop_count_in(loop_count_in),
        .wr_in(reg_wr_in),
        .at_end_out(loop_at_end),
        .restart_out(loop_restart),
        .loop_start_out(loop_start),
        .loop_end_out(loop_end_out),
        .loop_count_out(loop_count_out)
    );

    // Indirect link: written by instructions only.
    ctrl_reg u_indirect_link (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .wr_en_in(reg_wr_in.wr_lr0),
        .wr_data_in(reg_wr_in.data),
        .auto_en_in(1'b0),
        .auto_data_in(ZERO_WORD),
        .value_out(indirect_link)
    );

    // Return link: an instruction write outranks the entry loads.
    ctrl_reg u_return_link (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .wr_en_in(reg_wr_in.wr_lr1),
        .wr_data_in(reg_wr_in.data),
        .auto_en_in(lr1_auto_en),
        .auto_data_in(lr1_auto_data),
        .value_out(return_link)
    );

    // Mode and flag register with automatic loop-inhibit handling.
    ctrl_reg u_mode_flag (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .wr_en_in(reg_wr_in.wr_mode),
        .wr_data_in(reg_wr_in.data),
        .auto_en_in(mode_auto_en),
        .auto_data_in(mode_auto_data),
        .value_out(mode_flag)
    );

    // Saved mode copy, taken in the fourth entry cycle.
    ctrl_reg u_saved_mode (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .wr_en_in(1'b0),
        .wr_data_in(ZERO_WORD),
        .auto_en_in(s.st == INT_C4),
        .auto_data_in(mode_flag),
        .value_out(saved_mode_out)
    );

    // Instruction page register, changed by instructions.
    ctrl_reg u_instr_page (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .wr_en_in(reg_wr_in.wr_page),
        .wr_data_in(reg_wr_in.data),
        .auto_en_in(1'b0),
        .auto_data_in(ZERO_WORD),
        .value_out(instr_page)
    );

    // Saved page copy, taken in the second entry cycle; not writable.
    ctrl_reg u_saved_page (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .wr_en_in(1'b0),
        .wr_data_in(ZERO_WORD),
        .auto_en_in(s.st == INT_C2),
        .auto_data_in(instr_page),
        .value_out(saved_page_out)
    );

    // Outputs.
    assign fetch_addr_out = fetch_addr;
    assign exec_cancel_out = s.kill;
    assign int_state_out = s.st;
    assign loop_restart_out = loop_restart;
    assign pc_out = s.pc;
    assign indirect_link_out = indirect_link;
    assign return_link_out = return_link;
    assign mode_flag_out = mode_flag;
    assign instr_page_out = instr_page;
    assign loop_start_out = loop_start;
endmodule
`default_nettype wire

//--- program_flow_pkg.sv
// Shared types and constants for the program flow sequencer.
`default_nettype none
package program_flow_pkg;
    // Program address width and the register word type.
    localparam int ADDR_W = 16;
    typedef logic [ADDR_W-1:0] addr_t;

    // Reset values and fixed addresses.
    localparam addr_t RESET_VECTOR = 16'h0000;
    localparam addr_t LOOP_END_RESET = 16'hFFFF;
    localparam addr_t ZERO_WORD = 16'h0000;
    localparam addr_t ADDR_STEP = 16'h0001;
    localparam addr_t VECTOR_BASE = 16'h0020;
    localparam addr_t VECTOR_MASK = 16'h001F;

    // Position of the loop-inhibit flag inside the mode and flag register.
    localparam int LOOP_FLAG_BIT = 7;

    // Class of the instruction handed over by the decoder.
    typedef enum logic [7:0] {
        OP_OTHER     = 8'h01,
        OP_JUMP      = 8'h02,
        OP_COND_JUMP = 8'h04,
        OP_REG_JUMP  = 8'h08,
        OP_IRET      = 8'h10,
        OP_LOOP      = 8'h20,
        OP_VECTOR    = 8'h40,
        OP_COND_CALL = 8'h80
    } op_kind_t;

    // Instruction in the execute stage, with its evaluated condition.
    typedef struct packed {
        op_kind_t kind;
        logic cond_true;
        addr_t target;
    } exec_op_t;

    // Explicit register writes by instructions; they share one data word.
    typedef struct packed {
        logic wr_ls;
        logic wr_le;
        logic wr_lc;
        logic wr_lr0;
        logic wr_lr1;
        logic wr_mode;
        logic wr_page;
        addr_t data;
    } reg_write_t;

    // Interrupt entry states, one-hot.
    typedef enum logic [5:0] {
        INT_IDLE = 6'h01,
        INT_C1   = 6'h02,
        INT_C2   = 6'h04,
        INT_C3   = 6'h08,
        INT_C4   = 6'h10,
        INT_C5   = 6'h20
    } int_state_t;

    // Instructions that count as change-of-flow for cancellation.
    function automatic logic is_cof(input op_kind_t kind);
        is_cof = (kind == OP_JUMP) || (kind == OP_COND_JUMP) ||
                 (kind == OP_REG_JUMP) || (kind == OP_IRET) ||
                 (kind == OP_LOOP);
    endfunction
endpackage
`default_nettype wire

//--- ctrl_reg.sv
// One control register where an explicit write beats an automatic load.
`timescale 1ns/1ns
`default_nettype none
module ctrl_reg
    import program_flow_pkg::*;
#(
    parameter addr_t RESET_VALUE = ZERO_WORD
)
(
    input wire logic clk_in,         // Processor clock.
    input wire logic reset_in,       // Synchronous reset, active high.
    input wire logic wr_en_in,       // Explicit instruction write.
    input wire addr_t wr_data_in,    // Data of the explicit write.
    input wire logic auto_en_in,     // Automatic load by the sequencer.
    input wire addr_t auto_data_in,  // Data of the automatic load.
    output addr_t value_out          // Current register contents.
);
    typedef struct packed {
        addr_t value;
    } reg_state_t;

    reg_state_t s;
    reg_state_t next_s;

    // The explicit write is checked last so that it wins the cycle.
    always_comb
    begin
        next_s = s;
        if (auto_en_in)
            next_s.value = auto_data_in;
        if (wr_en_in)
            next_s.value = wr_data_in;
    end

    // State register.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            s <= '{value: RESET_VALUE};
        else
            s <= next_s;
    end

    assign value_out = s.value;
endmodule
`default_nettype wire

//--- loop_unit.sv
// Hardware loop registers with loop end detection and count decrement.
`timescale 1ns/1ns
`default_nettype none
module loop_unit
    import program_flow_pkg::*;
(
    input wire logic clk_in,          // Processor clock.
    input wire logic reset_in,        // Synchronous reset, active high.
    input wire addr_t fetch_addr_in,  // Current fetch address.
    input wire logic inhibit_in,      // Loop-inhibit flag from mode reg.
    input wire logic loop_exec_in,    // Loop start instruction executes.
    input wire addr_t loop_end_in,    // End address carried by it.
    input wire addr_t loop_count_in,  // Count carried by it.
    input wire reg_write_t wr_in,     // Explicit register writes.
    output logic at_end_out,          // Fetch comes from the loop end.
    output logic restart_out,         // A new loop round begins.
    output addr_t loop_start_out,     // Loop start register.
    output addr_t loop_end_out,       // Loop end register.
    output addr_t loop_count_out      // Loop count register.
);
    typedef struct packed {
        addr_t start;
        addr_t end_addr;
        addr_t count;
    } loop_state_t;

    loop_state_t s;
    loop_state_t next_s;
    addr_t eff_end;
    addr_t eff_count;

    // Values loaded by an executing loop instruction are forwarded, so a
    // one-instruction loop is caught on the very fetch of its body.
    assign eff_end = loop_exec_in ? loop_end_in : s.end_addr;
    assign eff_count = loop_exec_in ? loop_count_in : s.count;
    assign at_end_out = (fetch_addr_in == eff_end);
    assign restart_out = at_end_out && !inhibit_in &&
                         (eff_count != ZERO_WORD);

    // Loop registers: instruction load, direct writes, then decrement.
    always_comb
    begin
        next_s = s;
        if (loop_exec_in)
        begin
            next_s.start = fetch_addr_in;
            next_s.end_addr = loop_end_in;
            next_s.count = loop_count_in;
        end
        if (wr_in.wr_ls)
            next_s.start = wr_in.data;
        if (wr_in.wr_le)
            next_s.end_addr = wr_in.data;
        if (wr_in.wr_lc)
            next_s.count = wr_in.data;
        if (restart_out)
            next_s.count = eff_count - ADDR_STEP;
    end

    // State register; the end address resets to all ones.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
            s <= '{start: ZERO_WORD, end_addr: LOOP_END_RESET,
                   count: ZERO_WORD};
        else
            s <= next_s;
    end

    assign loop_start_out = s.start;
    assign loop_end_out = s.end_addr;
    assign loop_count_out = s.count;
endmodule
`default_nettype wire

//--- program_flow_checker.sv
// Concurrent checks on the ports of the program flow sequencer.
`timescale 1ns/1ns
`default_nettype none
module program_flow_checker
    import program_flow_pkg::*;
(
    input wire logic clk_in, // Clock.
    input wire logic reset_in, // Reset.
    input wire exec_op_t exec_op_in, // Execute op.
    input wire reg_write_t reg_wr_in, // Writes.
    input wire addr_t irq_vector_in, // Vector.
    input wire addr_t fetch_addr_out, // Fetch.
    input wire logic exec_cancel_out, // Cancel.
    input wire logic irq_accept_out, // Accept.
    input wire int_state_t int_state_out, // State.
    input wire logic loop_restart_out, // Restart.
    input wire addr_t pc_out, // Counter.
    input wire addr_t return_link_out, // Return link.
    input wire addr_t mode_flag_out, // Mode.
    input wire addr_t saved_mode_out, // Saved mode.
    input wire addr_t instr_page_out, // Page.
    input wire addr_t saved_page_out, // Saved page.
    input wire addr_t loop_start_out, // Loop start.
    input wire addr_t loop_end_out, // Loop end.
    input wire addr_t loop_count_out // Count.
);
    // One clock domain, so clock and reset are given once.
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // Entry runs cycles two to five, then idles.
    sequence entry_tail_s;
        int_state_out == INT_C2 ##1 int_state_out == INT_C3 ##1
        int_state_out == INT_C4 ##1 int_state_out == INT_C5 ##1
        int_state_out == INT_IDLE;
    endsequence
    entry_walk_a: assert property (
        irq_accept_out |=> int_state_out == INT_C1 ##1 entry_tail_s)
        else $error("interrupt entry order broken");
    return_capture_a: assert property (
        int_state_out == INT_C1 && !reg_wr_in.wr_lr1 |=>
        return_link_out == $past(fetch_addr_out))
        else $error("return link not captured");
    vector_fetch_a: assert property (
        int_state_out == INT_C2 |->
        fetch_addr_out == (VECTOR_BASE | (irq_vector_in & VECTOR_MASK)))
        else $error("vector fetch wrong");
    page_save_a: assert property (
        int_state_out == INT_C2 && !reg_wr_in.wr_mode |=>
        saved_page_out == $past(instr_page_out) && mode_flag_out[7])
        else $error("page save or inhibit wrong");
    mode_save_a: assert property (
        int_state_out == INT_C4 |=> saved_mode_out == $past(mode_flag_out))
        else $error("mode save wrong");
    link_write_a: assert property (
        reg_wr_in.wr_lr1 |=> return_link_out == $past(reg_wr_in.data))
        else $error("explicit link write lost");
    pc_step_a: assert property (
        !loop_restart_out |=> pc_out == $past(fetch_addr_out) + ADDR_STEP)
        else $error("counter step wrong");
    loop_round_a: assert property (
        loop_restart_out && exec_op_in.kind != OP_LOOP |=>
        pc_out == $past(loop_start_out) &&
        loop_count_out == $past(loop_count_out) - ADDR_STEP)
        else $error("loop round wrong");
    loop_detect_a: assert property (
        fetch_addr_out == loop_end_out && exec_op_in.kind != OP_LOOP |->
        loop_restart_out == (loop_count_out != ZERO_WORD &&
        !mode_flag_out[LOOP_FLAG_BIT]))
        else $error("loop end detection wrong");
    vector_slot_a: assert property (
        exec_op_in.kind == OP_VECTOR && !exec_cancel_out |=> exec_cancel_out)
        else $error("vector slot not cancelled");
endmodule
bind program_flow_sequencer program_flow_checker i_chk (.clk_in(clk_in),
    .reset_in(reset_in), .exec_op_in(exec_op_in), .reg_wr_in(reg_wr_in),
    .irq_vector_in(irq_vector_in), .fetch_addr_out(fetch_addr_out),
    .exec_cancel_out(exec_cancel_out), .irq_accept_out(irq_accept_out),
    .int_state_out(int_state_out), .loop_restart_out(loop_restart_out),
    .pc_out(pc_out), .return_link_out(return_link_out),
    .mode_flag_out(mode_flag_out), .saved_mode_out(saved_mode_out),
    .instr_page_out(instr_page_out), .saved_page_out(saved_page_out),
    .loop_start_out(loop_start_out), .loop_end_out(loop_end_out),
    .loop_count_out(loop_count_out));
`default_nettype wire

//--- irq_arbiter_model.sv
// Behavioural interrupt arbiter facing the sequencer.
`timescale 1ns/1ns
`default_nettype none
module irq_arbiter_model
    import program_flow_pkg::*;
(
    input wire logic clk_in, // Clock.
    input wire logic reset_in, // Reset.
    input wire logic raise_in, // Bench asks for an interrupt.
    input wire logic accept_in, // Core took the request.
    output logic irq_req_out, // Request level.
    output addr_t irq_vector_out // Vector address.
);
    logic [4:0] slot;
    // The request holds until taken, so a refused one is simply retried.
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            irq_req_out <= 1'b0;
            slot <= 5'h00;
        end
        else if (raise_in)
        begin
            irq_req_out <= 1'b1;
            slot <= slot + 5'h07;
        end
        else if (accept_in)
            irq_req_out <= 1'b0;
    end
    // Vectors stay inside the table window and hold through the entry.
    assign irq_vector_out = VECTOR_BASE | {11'h000, slot};
endmodule
`default_nettype wire

//--- tb_program_flow_sequencer.sv
// Self-checking bench for the program flow sequencer.
`timescale 1ns/1ns
`default_nettype none
module tb_program_flow_sequencer import program_flow_pkg::*;;
    logic clk_in, reset_in, raise, req, acc, cx, rs, go, prev;
    exec_op_t op;
    op_kind_t dk;
    reg_write_t wr;
    int_state_t st;
    addr_t lc, e, c1, rl, ls_v, le_v, cnt, vec, fa, pcv, ilk, rlk;
    addr_t mf, smf, ipg, spg, lsr, ler, lcr;
    int miscompares = 0;
    int checks_done = 0;
    int seed = 32'hC34A0151;
    int r, n;
    op_kind_t kinds[4] = '{OP_OTHER, OP_JUMP, OP_LOOP, OP_COND_CALL};
    program_flow_sequencer i_dut (.clk_in(clk_in), .reset_in(reset_in),
        .exec_op_in(op), .decode_kind_in(dk), .loop_count_in(lc),
        .reg_wr_in(wr), .irq_req_in(req), .irq_vector_in(vec),
        .fetch_addr_out(fa), .exec_cancel_out(cx), .irq_accept_out(acc),
        .int_state_out(st), .loop_restart_out(rs), .pc_out(pcv),
        .indirect_link_out(ilk), .return_link_out(rlk), .mode_flag_out(mf),
        .saved_mode_out(smf), .instr_page_out(ipg), .saved_page_out(spg),
        .loop_start_out(lsr), .loop_end_out(ler), .loop_count_out(lcr));
    irq_arbiter_model i_arb (.clk_in(clk_in), .reset_in(reset_in),
        .raise_in(raise), .accept_in(acc), .irq_req_out(req),
        .irq_vector_out(vec));
    // Processor clock, 8 ns period.
    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    task automatic check(input string what, input addr_t seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        if (miscompares == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Checks one fetch against the loop model, then moves past the edge.
    task automatic lin(input logic inh);
        #1 check("fetch", fa, e);
        if (!inh && e == le_v && cnt != ZERO_WORD)
        begin
            cnt = cnt - ADDR_STEP;
            e = ls_v;
        end
        else
            e = e + ADDR_STEP;
        @(posedge clk_in);
        #1;
    endtask
    // Inputs move 1 ns after the edge so no sampling race can occur.
    initial
    begin
        op = '{OP_OTHER, 1'b0, ZERO_WORD};
        dk = OP_OTHER;
        lc = ZERO_WORD;
        wr = '0;
        raise = 1'b0;
        reset_in = 1'b1;
        le_v = LOOP_END_RESET;
        cnt = ZERO_WORD;
        repeat (3) @(posedge clk_in);
        #1 reset_in = 1'b0;
        check("loop end", ler, LOOP_END_RESET);
        e = RESET_VECTOR;
        prev = 1'b0;
        // Random code with jumps, never a jump in a delay slot.
        repeat (300)
        begin
            r = $random(seed);
            op.kind = !prev && r[1] ?
                (r[3] ? OP_JUMP : OP_COND_JUMP) : OP_OTHER;
            op.cond_true = r[2];
            op.target = {1'b0, r[30:16]};
            prev = op.kind != OP_OTHER;
            go = op.kind == OP_JUMP || (prev && r[2]);
            e = go ? op.target : e;
            lin(1'b0);
            check("pc", pcv, e);
        end
        // Link registers feed indirect jumps and returns.
        op = '{OP_OTHER, 1'b0, ZERO_WORD};
        wr = {7'h08, 16'h1234};
        lin(1'b0);
        check("indirect", ilk, 16'h1234);
        wr = {7'h04, 16'h0456};
        op = '{OP_REG_JUMP, 1'b1, ZERO_WORD};
        e = 16'h1234;
        lin(1'b0);
        wr = '0;
        op.kind = OP_OTHER;
        lin(1'b0);
        op.kind = OP_IRET;
        e = 16'h0456;
        lin(1'b0);
        op.kind = OP_OTHER;
        lin(1'b0);
        op = '{OP_VECTOR, 1'b1, 16'h0789};
        e = 16'h0789;
        lin(1'b0);
        check("cancel", 16'(cx), 16'h0001);
        op = '{OP_JUMP, 1'b1, 16'h0F00};
        lin(1'b0);
        // Loop instruction with three rounds, over four words and over one.
        for (n = 3; n >= 0; n -= 3)
        begin
            le_v = e + 16'(n);
            op = '{OP_LOOP, 1'b0, le_v};
            lc = 16'h0002;
            ls_v = e;
            cnt = lc;
            lin(1'b0);
            op.kind = OP_OTHER;
            check("loop start", lsr, ls_v);
            repeat (14) lin(1'b0);
            check("count", lcr, cnt);
        end
        // Direct writes start a loop; the inhibit flag blocks it first.
        for (n = 0; n < 2; n++)
        begin
            wr = {7'h02, n ? ZERO_WORD : 16'h0080};
            lin(1'b1);
            ls_v = e + 16'h0002;
            le_v = e + 16'h0004;
            wr = {7'h40, ls_v};
            lin(1'b1);
            wr = {7'h20, le_v};
            lin(1'b1);
            cnt = 16'h0001;
            wr = {7'h10, cnt};
            lin(1'b1);
            wr = '0;
            repeat (8) lin(n == 0);
        end
        // Entries where the decode class decides on cancelling.
        raise = 1'b1;
        wr = {7'h01, 16'h0005};
        lin(1'b1);
        wr = '0;
        for (n = 0; n < 4; n++)
        begin
            raise = 1'b0;
            if (n > 0)
                check("accept", 16'(acc), ZERO_WORD);
            for (r = 0; acc !== 1'b1 && r < 20; r++)
                lin(1'b1);
            check("wait", 16'(r), 16'(n > 0));
            check("accept", 16'(acc), 16'h0001);
            lin(1'b1);
            dk = kinds[n];
            c1 = e;
            lin(1'b1);
            dk = OP_OTHER;
            wr = n == 2 ? {7'h04, 16'h0ABC} : '0;
            check("return link", rlk, c1);
            e = VECTOR_BASE | (16'(7 * n + 7) & VECTOR_MASK);
            lin(1'b1);
            wr = '0;
            check("cancel", 16'(cx),
                16'(n == 0 || n == 3));
            rl = (n == 0 || n == 3) ? c1 : c1 + ADDR_STEP;
            rl = n == 2 ? 16'h0ABC : rl;
            check("return link", rlk, rl);
            check("saved page", spg, 16'h0005);
            check("mode", mf, 16'h0080);
            lin(1'b1);
            lin(1'b1);
            check("saved mode", smf, 16'h0080);
            check("state", 16'(st), 16'(INT_C5));
            raise = n < 3;
            lin(1'b1);
        end
        stop_test;
    end
    // Whole run is under 600 cycles; this cuts a hang short.
    initial
    begin
        #20000;
        miscompares++;
        stop_test;
    end
endmodule
`default_nettype wire
